// ===== hw/lvdc_top.sv
// Low-voltage detector control: AXI4-Lite registers, source mux, glitch
// filter, trigger logic and interrupt or reset request.
// Assumes the analog comparators deliver one raw bit per source and that
// the two filter clocks arrive as free-running pins sampled on aclk.
//
// Functional notes
// - Control 0 at 0x00, resets zero.
// - Control 1 at 0x04, resets zero.
// - Control-0 bit 9 gates the interrupt.
// - Bits 7:4 select sixteen thresholds.
// - Bits 3:2 select monitored input.
// - Control-0 bit 1: interrupt or reset.
// - Control-0 bit 0 enables detector.
// - Control-1 bit 7: level trigger.
// - Control-1 bit 6: rising comparator edge.
// - Control-1 bit 5: falling comparator edge.
// - Control-1 bit 4 selects filter clock.
// - Bits 3:1 select filter width.
// - Control-1 bit 0 enables filter.
// - Status bit 0 flag, write-zero clears.
// - Status bit 1 shows filtered level.
`timescale 1ns/1ps
module lvdc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog front end
  input wire logic [3:0] comparator_raw,
  output logic [3:0] threshold_select,
  output logic [1:0] source_select,
  output logic analog_enable,
  // Filter clock pins
  input wire logic rc_osc_clk,
  input wire logic high_speed_internal_osc,
  // Responses
  output logic irq,
  output logic system_reset_req,
  output logic filtered_out
);
  import lvdc_pkg::*;

  logic [31:0] ctrl0_q, ctrl0_d, ctrl1_q, ctrl1_d, mask_q, mask_d;
  logic flag_q, flag_d;
  logic aw_held_q, w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  lvdc_wstate_t wst_q;
  logic bvalid_q, rvalid_q;
  logic awready_q, wready_q, arready_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [2:0] cmp_sync_q, rc_sync_q, hs_sync_q;
  logic cmp_stable_q, rc_stable_q, hs_stable_q, fclk_prev_q;
  logic [LVDC_FCNT_W-1:0] fcnt_q, fcnt_d;
  logic filt_q, filt_d, level_q, level_prev_q;
  logic irq_q, rst_req_q;
  logic [3:0] thr_q;
  logic [1:0] src_q;
  logic aen_q;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb,
                                        input logic [31:0] wmask);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r & wmask;
  endfunction

  // Second and third stages must agree, else the old value holds; the first synchroniser stage feeds only stage 2.
  function automatic logic agree(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // Write path: address and data are captured independently, in any order.
  wire aw_take = s_axi_awvalid && awready_q;
  wire w_take = s_axi_wvalid && wready_q;
  wire wr_fire = aw_held_q && w_held_q && wst_q == LVDC_WIDLE;
  // Readies are registered, so each is worked out from the state that its
  // path holds after this edge; no ready ever follows a valid in one cycle.
  wire wr_idle_d = (wst_q == LVDC_WIDLE) ? !wr_fire : s_axi_bready;
  wire awready_d = wr_idle_d && !aw_held_q && !aw_take;
  wire wready_d = wr_idle_d && !w_held_q && !w_take;
  wire sel_c0 = awaddr_q[3:2] == LVDC_OFS_CTRL0[3:2];
  wire sel_c1 = awaddr_q[3:2] == LVDC_OFS_CTRL1[3:2];
  wire sel_st = awaddr_q[3:2] == LVDC_OFS_STAT[3:2];
  wire sel_mk = awaddr_q[3:2] == LVDC_OFS_MASK[3:2];
  wire rd_take = s_axi_arvalid && arready_q;
  wire arready_d = !rd_take && !(rvalid_q && !s_axi_rready);
  wire rd_st = s_axi_araddr[3:2] == LVDC_OFS_STAT[3:2];
  // A status read clears the sticky flag; a new interrupt-mode trigger still wins.
  wire rd_clr = rd_take && rd_st;
  wire wr_clr = wr_fire && sel_st && wstrb_q[0] && !wdata_q[LVDC_ST_FLAG];

  wire det_en = ctrl0_q[LVDC_C0_EN];
  wire cmp_sel = comparator_raw[ctrl0_q[LVDC_C0_SRC_LO +: 2]];
  wire fclk_now = ctrl1_q[LVDC_C1_FCLK] ? hs_stable_q : rc_stable_q;
  wire fclk_tick = fclk_now && !fclk_prev_q;
  wire [2:0] fw_code = ctrl1_q[LVDC_C1_FW_LO +: 3];
  logic [LVDC_FCNT_W-1:0] fw_cycles;

  always_comb begin
    case (fw_code)
      3'h0: fw_cycles = LVDC_FW_T0;
      3'h1: fw_cycles = LVDC_FW_T1;
      3'h2: fw_cycles = LVDC_FW_T2;
      3'h3: fw_cycles = LVDC_FW_T3;
      3'h4: fw_cycles = LVDC_FW_T4;
      3'h5: fw_cycles = LVDC_FW_T5;
      3'h6: fw_cycles = LVDC_FW_T6;
      default: fw_cycles = LVDC_FW_T7;
    endcase
  end

  // The filter output moves only after the input has differed from it
  // for the selected number of filter-clock ticks.
  always_comb begin
    fcnt_d = fcnt_q;
    filt_d = filt_q;
    if (cmp_stable_q == filt_q) begin
      fcnt_d = '0;
    end else if (fclk_tick) begin
      if (fcnt_q + 10'h001 >= fw_cycles) begin
        filt_d = cmp_stable_q;
        fcnt_d = '0;
      end else begin
        fcnt_d = fcnt_q + 10'h001;
      end
    end
  end

  wire level_now = ctrl1_q[LVDC_C1_FEN] ? filt_q : cmp_stable_q;
  wire t_level = ctrl1_q[LVDC_C1_LEVEL] && level_q;
  wire t_rise = ctrl1_q[LVDC_C1_RISE_T] && level_q && !level_prev_q;
  wire t_fall = ctrl1_q[LVDC_C1_FALL_T] && !level_q && level_prev_q;
  wire trig = det_en && (t_level || t_rise || t_fall);
  wire trig_irq = trig && !ctrl0_q[LVDC_C0_ACT];
  wire trig_rst = trig && ctrl0_q[LVDC_C0_ACT];

  always_comb begin
    flag_d = flag_q;
    if (wr_clr || rd_clr) begin
      flag_d = 1'b0;
    end
    if (trig_irq) begin
      flag_d = 1'b1;
    end
  end

  assign ctrl0_d = (wr_fire && sel_c0)
    ? merge(ctrl0_q, wdata_q, wstrb_q, LVDC_CTRL0_WMASK) : ctrl0_q;
  assign ctrl1_d = (wr_fire && sel_c1)
    ? merge(ctrl1_q, wdata_q, wstrb_q, LVDC_CTRL1_WMASK) : ctrl1_q;
  assign mask_d = (wr_fire && sel_mk)
    ? merge(mask_q, wdata_q, wstrb_q, LVDC_MASK_WMASK) : mask_q;

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[3:2])
      LVDC_OFS_CTRL0[3:2]: rd_mux = ctrl0_q;
      LVDC_OFS_CTRL1[3:2]: rd_mux = ctrl1_q;
      LVDC_OFS_STAT[3:2]: begin
        rd_mux[LVDC_ST_FLAG] = flag_q;
        rd_mux[LVDC_ST_FLEVEL] = level_q;
      end
      LVDC_OFS_MASK[3:2]: rd_mux = mask_q;
      default: rd_ok = 1'b0;
    endcase
  end
  wire wr_ok = sel_c0 || sel_c1 || sel_st || sel_mk;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= LVDC_CTRL0_RST;
      ctrl1_q <= LVDC_CTRL1_RST;
      mask_q <= LVDC_MASK_RST;
      flag_q <= 1'b0;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
      mask_q <= mask_d;
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      wst_q <= LVDC_WIDLE;
      bvalid_q <= 1'b0;
      bresp_q <= LVDC_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      case (wst_q)
        LVDC_WIDLE: begin
          if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? LVDC_RESP_OKAY : LVDC_RESP_SLVERR;
            wst_q <= LVDC_WRESP;
          end
        end
        LVDC_WRESP: begin
          if (s_axi_bready) begin
            bvalid_q <= 1'b0;
            wst_q <= LVDC_WIDLE;
          end
        end
        default: wst_q <= LVDC_WIDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= LVDC_RESP_OKAY;
      arready_q <= 1'b0;
    end else begin
      arready_q <= arready_d;
      if (rd_take) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? LVDC_RESP_OKAY : LVDC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_sync_q <= 3'h0;
      rc_sync_q <= 3'h0;
      hs_sync_q <= 3'h0;
      cmp_stable_q <= 1'b0;
      rc_stable_q <= 1'b0;
      hs_stable_q <= 1'b0;
      fclk_prev_q <= 1'b0;
      fcnt_q <= '0;
      filt_q <= 1'b0;
      level_q <= 1'b0;
      level_prev_q <= 1'b0;
    end else begin
      cmp_sync_q <= {cmp_sync_q[1:0], cmp_sel};
      rc_sync_q <= {rc_sync_q[1:0], rc_osc_clk};
      hs_sync_q <= {hs_sync_q[1:0], high_speed_internal_osc};
      cmp_stable_q <= agree(cmp_sync_q, cmp_stable_q);
      rc_stable_q <= agree(rc_sync_q, rc_stable_q);
      hs_stable_q <= agree(hs_sync_q, hs_stable_q);
      fclk_prev_q <= fclk_now;
      fcnt_q <= fcnt_d;
      filt_q <= filt_d;
      level_q <= level_now;
      level_prev_q <= level_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
      rst_req_q <= 1'b0;
      thr_q <= 4'h0;
      src_q <= 2'h0;
      aen_q <= 1'b0;
    end else begin
      irq_q <= flag_q && mask_q[LVDC_ST_FLAG] && ctrl0_q[LVDC_C0_IE];
      rst_req_q <= trig_rst;
      thr_q <= ctrl0_q[LVDC_C0_TH_LO +: 4];
      src_q <= ctrl0_q[LVDC_C0_SRC_LO +: 2];
      aen_q <= det_en;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign irq = irq_q;
  assign system_reset_req = rst_req_q;
  assign filtered_out = level_q;
  assign threshold_select = thr_q;
  assign source_select = src_q;
  assign analog_enable = aen_q;
endmodule

// ===== hw/lvdc_pkg.sv
// Package of the low-voltage detector control block: register map,
// field positions, reset values and filter width table.
// Assumes a 32-bit AXI4-Lite register bus and a 10 MHz system clock.
package lvdc_pkg;
  localparam logic [3:0] LVDC_OFS_CTRL0 = 4'h0;
  localparam logic [3:0] LVDC_OFS_CTRL1 = 4'h4;
  localparam logic [3:0] LVDC_OFS_STAT = 4'h8;
  localparam logic [3:0] LVDC_OFS_MASK = 4'hC;
  localparam logic [31:0] LVDC_CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] LVDC_CTRL1_RST = 32'h0000_0000;
  localparam logic [31:0] LVDC_MASK_RST = 32'h0000_0000;
  localparam logic [31:0] LVDC_CTRL0_WMASK = 32'h0000_02FF;
  localparam logic [31:0] LVDC_CTRL1_WMASK = 32'h0000_00FF;
  localparam logic [31:0] LVDC_MASK_WMASK = 32'h0000_0001;
  localparam int LVDC_C0_EN = 0;
  localparam int LVDC_C0_ACT = 1;
  localparam int LVDC_C0_SRC_LO = 2;
  localparam int LVDC_C0_TH_LO = 4;
  localparam int LVDC_C0_IE = 9;
  localparam int LVDC_C1_FEN = 0;
  localparam int LVDC_C1_FW_LO = 1;
  localparam int LVDC_C1_FCLK = 4;
  localparam int LVDC_C1_FALL_T = 5;
  localparam int LVDC_C1_RISE_T = 6;
  localparam int LVDC_C1_LEVEL = 7;
  localparam int LVDC_ST_FLAG = 0;
  localparam int LVDC_ST_FLEVEL = 1;
  localparam int LVDC_FCNT_W = 10;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T0 = 10'h001;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T1 = 10'h003;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T2 = 10'h005;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T3 = 10'h00F;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T4 = 10'h03F;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T5 = 10'h0FF;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T6 = 10'h3FF;
  localparam logic [LVDC_FCNT_W-1:0] LVDC_FW_T7 = 10'h3FF;
  localparam logic [1:0] LVDC_RESP_OKAY = 2'h0;
  localparam logic [1:0] LVDC_RESP_SLVERR = 2'h2;
  typedef enum logic [0:0] {
    LVDC_WIDLE = 1'b0,
    LVDC_WRESP = 1'b1
  } lvdc_wstate_t;
endpackage

// ===== sim/lvdc_top_asserts.sv
// Checker of lvdc_top: bus handshakes and analog control outputs.
// Bound into lvdc_top and sees its ports only.
`timescale 1ns/1ps
module lvdc_top_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog control and reset request
  input wire logic [3:0] threshold_select,
  input wire logic [1:0] source_select,
  input wire logic analog_enable,
  input wire logic system_reset_req
);
  import lvdc_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("bvalid dropped early");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("no read response");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data not held");
  property p_rd_okay;
    $rose(s_axi_rvalid) && $past(s_axi_araddr[1:0]) == 2'h0
      |-> s_axi_rresp == LVDC_RESP_OKAY;
  endproperty
  a_rd_okay: assert property (p_rd_okay)
    else $error("mapped read refused");
  property p_rst_en;
    system_reset_req |-> analog_enable || $past(analog_enable);
  endproperty
  a_rst_en: assert property (p_rst_en)
    else $error("reset request while disabled");
  property p_thr;
    $changed(threshold_select) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_thr: assert property (p_thr)
    else $error("threshold moved without write");
  property p_src;
    $changed(source_select) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_src: assert property (p_src)
    else $error("source moved without write");
endmodule

// ===== sim/lvdc_top_tb_top.sv
// Testbench of lvdc_top: register map, triggers, filter and responses.
// Assumes lvdc_pkg, lvdc_top and lvdc_top_asserts are compiled first.
`timescale 1ns/1ps
module lvdc_top_tb_top;
  import lvdc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
  logic [3:0] s_axi_wstrb = 4'hF, comparator_raw = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic rc_osc_clk = 1'b0, high_speed_internal_osc = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, analog_enable, irq, system_reset_req, filtered_out;
  logic [1:0] s_axi_bresp, s_axi_rresp, source_select;
  logic [31:0] s_axi_rdata;
  logic [3:0] threshold_select;
  logic [4:0] div_q = 5'h0;
  logic [2:0] obs;
  int n_mismatch = 0, samples_checked = 0;
  assign obs = {filtered_out, system_reset_req, irq};
  lvdc_top lvdc_top_i (.*);
  initial begin
    forever #50 aclk = ~aclk;
  end
  // Filter clocks well below aclk/4, as the pin samplers need.
  always @(posedge aclk) begin
    div_q <= div_q + 5'h1;
    high_speed_internal_osc <= div_q[2];
    rc_osc_clk <= div_q[4];
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: %h vs %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int i);
    if (i >= 300) begin
      n_mismatch++;
      $display("unexpected at %0t: timeout", $time);
      stop_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (i = 0; i < 300 && !(s_axi_bvalid && s_axi_bready); i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      s_axi_bready <= s_axi_bvalid && !s_axi_bready;
    end
    tmo(i);
    chk({30'h0, s_axi_bresp}, {30'h0, LVDC_RESP_OKAY});
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (i = 0; i < 300 && !(s_axi_rvalid && s_axi_rready); i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      s_axi_rready <= s_axi_rvalid && !s_axi_rready;
    end
    tmo(i);
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, LVDC_RESP_OKAY});
  endtask
  task automatic wfor(input int s, input logic e);
    int i;
    for (i = 0; i < 300 && obs[s] !== e; i++) @(posedge aclk);
    tmo(i);
    chk(32'(obs[s]), 32'(e));
  endtask
  task automatic t_regs();
    int i;
    chk({28'h0, obs, analog_enable}, 32'h0);
    rd(LVDC_OFS_CTRL0, 32'h0);
    rd(LVDC_OFS_CTRL1, 32'h0);
    rd(LVDC_OFS_STAT, 32'h0);
    rd(4'h6, 32'h0);
    wr(LVDC_OFS_CTRL1, 32'hFFFF_FF00);
    rd(LVDC_OFS_CTRL1, 32'h0);
    for (i = 0; i < 16; i++) begin
      wr(LVDC_OFS_CTRL0, 32'((i << 4) | ((i & 3) << 2)));
      rd(LVDC_OFS_CTRL0, 32'((i << 4) | ((i & 3) << 2)));
      chk({26'h0, threshold_select, source_select},
          32'((i << 2) | (i & 3)));
    end
    $display("t_regs done");
  endtask
  task automatic t_level();
    wr(LVDC_OFS_MASK, 32'h1);
    wr(LVDC_OFS_CTRL1, 32'h80);
    wr(LVDC_OFS_CTRL0, 32'h209);
    comparator_raw <= 4'h4;
    wfor(0, 1'b1);
    chk(32'(analog_enable), 32'h1);
    rd(LVDC_OFS_STAT, 32'h3);
    wr(LVDC_OFS_MASK, 32'h0);
    wfor(0, 1'b0);
    wr(LVDC_OFS_MASK, 32'h1);
    wfor(0, 1'b1);
    wr(LVDC_OFS_CTRL0, 32'h009);
    wfor(0, 1'b0);
    comparator_raw <= 4'h0;
    wfor(2, 1'b0);
    wr(LVDC_OFS_CTRL0, 32'h209);
    wfor(0, 1'b1);
    wr(LVDC_OFS_STAT, 32'h1);
    chk(32'(irq), 32'h1);
    wr(LVDC_OFS_STAT, 32'h0);
    wfor(0, 1'b0);
    $display("t_level done");
  endtask
  task automatic t_edge();
    wr(LVDC_OFS_CTRL1, 32'h40);
    comparator_raw <= 4'h4;
    wfor(0, 1'b1);
    wr(LVDC_OFS_STAT, 32'h0);
    wfor(0, 1'b0);
    comparator_raw <= 4'h0;
    wfor(2, 1'b0);
    rd(LVDC_OFS_STAT, 32'h0);
    wr(LVDC_OFS_CTRL1, 32'h20);
    comparator_raw <= 4'h4;
    wfor(2, 1'b1);
    rd(LVDC_OFS_STAT, 32'h2);
    comparator_raw <= 4'h0;
    wfor(0, 1'b1);
    wr(LVDC_OFS_STAT, 32'h0);
    $display("t_edge done");
  endtask
  task automatic t_reset();
    wr(LVDC_OFS_CTRL1, 32'h80);
    wr(LVDC_OFS_CTRL0, 32'h20B);
    comparator_raw <= 4'h4;
    wfor(1, 1'b1);
    rd(LVDC_OFS_STAT, 32'h2);
    wr(LVDC_OFS_CTRL0, 32'h20A);
    wfor(1, 1'b0);
    chk(32'(analog_enable), 32'h0);
    comparator_raw <= 4'h0;
    $display("t_reset done");
  endtask
  task automatic t_filter();
    int k, i;
    logic seen;
    logic [31:0] cfg [3] = '{32'h03, 32'h13, 32'h00};
    int len [3] = '{40, 40, 6};
    wr(LVDC_OFS_CTRL0, 32'h009);
    for (k = 0; k < 3; k++) begin
      wr(LVDC_OFS_CTRL1, cfg[k]);
      seen = 1'b0;
      comparator_raw <= 4'h4;
      for (i = 0; i < 120; i++) begin
        @(posedge aclk);
        if (i == len[k]) comparator_raw <= 4'h0;
        seen = seen | (filtered_out === 1'b1);
      end
      chk(32'(seen), 32'(k != 0));
    end
    $display("t_filter done");
  endtask
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_level();
    t_edge();
    t_reset();
    t_filter();
    stop_test();
  end
endmodule
bind lvdc_top lvdc_top_asserts lvdc_top_asserts_i (.*);
